// file: rtl/dbsfm_map.svh
// Register offsets, field positions, reset values and timing figures
// of the dual buck supervisor. Included by the supervisor module file only.
`ifndef DBSFM_MAP_SVH
`define DBSFM_MAP_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DBSFM_CTRL_OFS 8'h00
`define DBSFM_STATUS_OFS 8'h04
`define DBSFM_CTRL_RST 2'h3
`define DBSFM_CTRL_ALLOW 0
`define DBSFM_STAT_STATE 0
`define DBSFM_STAT_PG 3
`define DBSFM_STAT_CH_EN 4
`define DBSFM_STAT_HS_INH 6
`define DBSFM_STAT_UV85 8
`define DBSFM_STAT_AB90 10
`define DBSFM_STAT_OC 12
`define DBSFM_STAT_HOT 14
`define DBSFM_STAT_SKIP 15
`define DBSFM_STAT_PIN 16
`define DBSFM_RESP_OKAY 2'h0
`define DBSFM_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define DBSFM_CLK_MHZ 100
`define DBSFM_UV_DEGLITCH_MS 11
`define DBSFM_OT_DEGLITCH_US 100
`define DBSFM_OC_LIMIT_MS 12
`define DBSFM_HICCUP_OFF_MS 20
`define DBSFM_RESET_PERIOD_MS 32
`define DBSFM_CH_RESTART_CYC 4'hf

`endif

// file: rtl/dbsfm_pkg.sv
// Types shared by the dual buck supervisor design files.
// Assumes nothing of its surroundings.
package dbsfm_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_HICCUP = 3'h2,
        ST_THERMAL = 3'h4
    } dbsfm_state_t;
endpackage

// file: rtl/dbsfm_flt_if.sv
// Carrier between the supervisor and one deglitch filter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface dbsfm_flt_if;
    logic raw;
    logic clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface // dbsfm_flt_if

// file: rtl/dbsfm_deglitch.sv
// Two-edge deglitch filter for one synchronised comparator flag.
// Assumes raw is already in the clock domain.
`timescale 1ns/10ps
module dbsfm_deglitch #(
    parameter int CYC = 16
) (
    input logic clock_in, // Oscillator clock
    input logic reset_in, // Synchronous reset, active high
    dbsfm_flt_if.filt link // Raw flag in, filtered flag out
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic clean;
    } dbsfm_flt_t;

    dbsfm_flt_t q;
    dbsfm_flt_t n;

    always_comb begin
        n = q;
        if (link.raw != q.clean) begin
            if (q.cnt == CW'(CYC - 1)) begin
                n.clean = link.raw;
                n.cnt = '0;
            end else begin
                n.cnt = q.cnt + 1'h1;
            end
        end else begin
            n.cnt = '0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign link.clean = q.clean;

    AST_FILT_STABLE: assert property (@(posedge clock_in)
        disable iff (reset_in)
        ($changed(q.clean) && !$past(reset_in)) |->
        ($past(q.cnt) == CW'(CYC - 1) && $past(link.raw) == q.clean))
        else $error("Filter output changed before the deglitch time.");
endmodule // dbsfm_deglitch

// file: rtl/dbsfm_supervisor.sv
// Supervisor and fault manager for a dual step-down converter, with an
// AXI4-Lite register slave. Assumes comparator flags and pins arrive
// asynchronously, and switch_tick_in is a one-cycle pulse on clock_in.
`timescale 1ns/10ps
`include "dbsfm_map.svh"
module dbsfm_supervisor #(
    parameter int UV_DEG_CYC = `DBSFM_UV_DEGLITCH_MS * 1000 * `DBSFM_CLK_MHZ,
    parameter int OT_DEG_CYC = `DBSFM_OT_DEGLITCH_US * `DBSFM_CLK_MHZ,
    parameter int OC_CYC = `DBSFM_OC_LIMIT_MS * 1000 * `DBSFM_CLK_MHZ,
    parameter int HIC_CYC = `DBSFM_HICCUP_OFF_MS * 1000 * `DBSFM_CLK_MHZ,
    parameter int RP_CYC = `DBSFM_RESET_PERIOD_MS * 1000 * `DBSFM_CLK_MHZ
) (
    input logic clock_in, // 100 MHz oscillator clock
    input logic reset_in, // Synchronous reset, active high
    input logic [1:0] under_85_in, // Output below 85 percent
    input logic [1:0] above_90_in, // Output above 90 percent
    input logic [1:0] overcurrent_in, // Current limit reached
    input logic [1:0] feedback_sense_over_in, // Feedback above 109 pct
    input logic [1:0] feedback_sense_clear_in, // Feedback below 107 pct
    input logic temp_trip_in, // Die above 160 degrees
    input logic temp_cool_in, // Die below 140 degrees
    input logic light_load_select_alt_in, // Low-power select pin
    input logic switch_tick_in, // Switching cycle start pulse
    input logic power_ok_in, // Power-good pin level
    output logic power_ok_out, // Power-good drive level
    output logic power_ok_oe_out, // Power-good pull-down enable
    output logic [1:0] channel_enable_out, // Converter run
    output logic [1:0] overshoot_guard_out, // High-side inhibit
    output logic pulse_skip_out, // Pulse-skipping mode
    input logic [7:0] s_axi_awaddr_in, // Write address
    input logic s_axi_awvalid_in, // Write address valid
    output logic s_axi_awready_out, // Write address ready
    input logic [31:0] s_axi_wdata_in, // Write data
    input logic [3:0] s_axi_wstrb_in, // Write strobes
    input logic s_axi_wvalid_in, // Write data valid
    output logic s_axi_wready_out, // Write data ready
    output logic [1:0] s_axi_bresp_out, // Write response
    output logic s_axi_bvalid_out, // Write response valid
    input logic s_axi_bready_in, // Write response ready
    input logic [7:0] s_axi_araddr_in, // Read address
    input logic s_axi_arvalid_in, // Read address valid
    output logic s_axi_arready_out, // Read address ready
    output logic [31:0] s_axi_rdata_out, // Read data
    output logic [1:0] s_axi_rresp_out, // Read response
    output logic s_axi_rvalid_out, // Read data valid
    input logic s_axi_rready_in // Read data ready
);
    localparam int OCW = $clog2(OC_CYC + 1);
    localparam int HCW = $clog2(HIC_CYC + 1);
    localparam int RPW = $clog2(RP_CYC + 1);

    typedef struct packed {
        dbsfm_pkg::dbsfm_state_t st;
        logic [13:0] s1;
        logic [13:0] s2;
        logic [1:0] allow;
        logic [1:0][OCW-1:0] oc_cnt;
        logic [1:0][3:0] loc_cnt;
        logic [HCW-1:0] hic_cnt;
        logic [RPW-1:0] rp_cnt;
        logic pg;
        logic pg_oe;
        logic [1:0] ch_en;
        logic [1:0] hs_inh;
        logic skip;
        logic aw_hold;
        logic w_hold;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [RPW-1:0] chk_q;
        logic [HCW-1:0] chk_h;
    } dbsfm_sup_t;

    localparam dbsfm_sup_t SUP_RST = '{
        st: dbsfm_pkg::ST_RUN,
        allow: `DBSFM_CTRL_RST,
        pg_oe: 1'h1,
        default: '0
    };

    dbsfm_sup_t q;
    dbsfm_sup_t n;
    logic [4:0] flt_clean;
    logic [1:0] uv85;
    logic [1:0] ab90;
    logic hot;
    logic [31:0] status;

    // ****************************************************************
    // Deglitch filters: two output-voltage flags (under 85, above 90) per channel, one thermal
    // ****************************************************************
    dbsfm_flt_if flt[5] ();

    for (genvar k = 0; k < 5; k++) begin : g_flt
        assign flt[k].raw = (k == 4) ? q.s2[10] : q.s2[k];
        assign flt_clean[k] = flt[k].clean;
        dbsfm_deglitch #(
            .CYC((k == 4) ? OT_DEG_CYC : UV_DEG_CYC)
        ) u_flt (
            .clock_in(clock_in),
            .reset_in(reset_in),
            .link(flt[k])
        );
    end

    assign uv85 = flt_clean[1:0];
    assign ab90 = flt_clean[3:2];
    assign hot = flt_clean[4];

    always_comb begin
        status = '0;
        status[`DBSFM_STAT_STATE +: 3] = q.st;
        status[`DBSFM_STAT_PG] = q.pg;
        status[`DBSFM_STAT_CH_EN +: 2] = q.ch_en;
        status[`DBSFM_STAT_HS_INH +: 2] = q.hs_inh;
        status[`DBSFM_STAT_UV85 +: 2] = uv85;
        status[`DBSFM_STAT_AB90 +: 2] = ab90;
        status[`DBSFM_STAT_OC +: 2] = q.s2[5:4];
        status[`DBSFM_STAT_HOT] = hot;
        status[`DBSFM_STAT_SKIP] = q.skip;
        status[`DBSFM_STAT_PIN] = q.s2[13];
    end

    always_comb begin
        n = q;
        n.s1 = {power_ok_in, light_load_select_alt_in, temp_cool_in,
                temp_trip_in, feedback_sense_clear_in,
                feedback_sense_over_in, overcurrent_in, above_90_in,
                under_85_in};
        n.s2 = q.s1;
        n.skip = q.s2[12];
        for (int i = 0; i < 2; i++) begin
            if (q.s2[6 + i]) begin
                n.hs_inh[i] = 1'h1;
            end else if (q.s2[8 + i] && switch_tick_in) begin
                n.hs_inh[i] = 1'h0;
            end
        end

        // ************************************************************
        // Fault sequencing
        // ************************************************************
        case (q.st)
            dbsfm_pkg::ST_RUN: begin
                for (int i = 0; i < 2; i++) begin
                    if (q.loc_cnt[i] != 4'h0) begin
                        n.loc_cnt[i] = q.loc_cnt[i] - 1'h1;
                    end
                    if (q.s2[4 + i]) begin
                        if (q.oc_cnt[i] != OCW'(OC_CYC)) begin
                            n.oc_cnt[i] = q.oc_cnt[i] + 1'h1;
                        end
                    end else if (q.oc_cnt[i] != '0) begin
                        n.oc_cnt[i] = '0;
                        n.loc_cnt[i] = `DBSFM_CH_RESTART_CYC;
                    end
                end
                if (hot) begin
                    n.st = dbsfm_pkg::ST_THERMAL;
                    n.oc_cnt = '0;
                    n.loc_cnt = '0;
                end else if (q.oc_cnt[0] == OCW'(OC_CYC) ||
                             q.oc_cnt[1] == OCW'(OC_CYC)) begin
                    n.st = dbsfm_pkg::ST_HICCUP;
                    n.hic_cnt = '0;
                    n.oc_cnt = '0;
                    n.loc_cnt = '0;
                end
            end
            dbsfm_pkg::ST_HICCUP: begin
                n.hic_cnt = q.hic_cnt + 1'h1;
                if (hot) begin
                    n.st = dbsfm_pkg::ST_THERMAL;
                end else if (q.hic_cnt == HCW'(HIC_CYC - 1)) begin
                    n.st = dbsfm_pkg::ST_RUN;
                end
            end
            dbsfm_pkg::ST_THERMAL: begin
                if (!hot && q.s2[11]) begin
                    n.st = dbsfm_pkg::ST_RUN;
                end
            end
            default: begin
                n.st = dbsfm_pkg::ST_RUN;
            end
        endcase

        for (int i = 0; i < 2; i++) begin
            n.ch_en[i] = (n.st == dbsfm_pkg::ST_RUN) && q.allow[i] &&
                         (n.loc_cnt[i] == 4'h0);
        end

        // ************************************************************
        // Power-good with reset period
        // ************************************************************
        // forced low
        if (n.st != dbsfm_pkg::ST_RUN || uv85 != 2'h0) begin
            n.pg = 1'h0;
            n.rp_cnt = '0;
        end else if (!q.pg) begin
            if (ab90 == 2'h3) begin
                if (q.rp_cnt == RPW'(RP_CYC - 1)) begin
                    n.pg = 1'h1;
                end else begin
                    n.rp_cnt = q.rp_cnt + 1'h1;
                end
            end else begin
                n.rp_cnt = '0;
            end
        end
        n.pg_oe = !n.pg;

        if (n.st == dbsfm_pkg::ST_RUN && ab90 == 2'h3 && uv85 == 2'h0) begin
            if (q.chk_q != RPW'(RP_CYC)) begin
                n.chk_q = q.chk_q + 1'h1;
            end
        end else begin
            n.chk_q = '0;
        end
        if (n.st != dbsfm_pkg::ST_HICCUP) begin
            n.chk_h = '0;
        end else if (q.st == dbsfm_pkg::ST_HICCUP) begin
            n.chk_h = q.chk_h + 1'h1;
        end else begin
            n.chk_h = HCW'(1);
        end

        // ************************************************************
        // AXI4-Lite slave
        // ************************************************************
        if (q.bvalid && s_axi_bready_in) begin
            n.bvalid = 1'h0;
        end
        if (s_axi_awvalid_in && q.awready) begin
            n.aw_hold = 1'h1;
            n.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && q.wready) begin
            n.w_hold = 1'h1;
            n.wdata = s_axi_wdata_in;
            n.wstrb = s_axi_wstrb_in;
        end
        if (q.aw_hold && q.w_hold && !q.bvalid) begin
            n.aw_hold = 1'h0;
            n.w_hold = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = `DBSFM_RESP_SLVERR;
            if (q.awaddr[7:2] == `DBSFM_CTRL_OFS >> 2) begin
                n.bresp = `DBSFM_RESP_OKAY;
                if (q.wstrb[0]) begin
                    n.allow = q.wdata[`DBSFM_CTRL_ALLOW +: 2];
                end
            end
        end
        n.awready = !n.aw_hold && !n.bvalid;
        n.wready = !n.w_hold && !n.bvalid;

        if (q.rvalid && s_axi_rready_in) begin
            n.rvalid = 1'h0;
        end
        if (s_axi_arvalid_in && q.arready) begin
            n.rvalid = 1'h1;
            n.rresp = `DBSFM_RESP_OKAY;
            n.rdata = '0;
            if (s_axi_araddr_in[7:2] == `DBSFM_CTRL_OFS >> 2) begin
                n.rdata[`DBSFM_CTRL_ALLOW +: 2] = q.allow;
            end else if (s_axi_araddr_in[7:2] == `DBSFM_STATUS_OFS >> 2) begin
                n.rdata = status;
            end else begin
                n.rresp = `DBSFM_RESP_SLVERR;
            end
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            q <= SUP_RST;
        end else begin
            q <= n;
        end
    end

    assign power_ok_out = q.pg;
    assign power_ok_oe_out = q.pg_oe;
    assign channel_enable_out = q.ch_en;
    assign overshoot_guard_out = q.hs_inh;
    assign pulse_skip_out = q.skip;
    assign s_axi_awready_out = q.awready;
    assign s_axi_wready_out = q.wready;
    assign s_axi_bresp_out = q.bresp;
    assign s_axi_bvalid_out = q.bvalid;
    assign s_axi_arready_out = q.arready;
    assign s_axi_rdata_out = q.rdata;
    assign s_axi_rresp_out = q.rresp;
    assign s_axi_rvalid_out = q.rvalid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    AST_PG_UV_LOW: assert property ((uv85 != 2'h0) |=> !power_ok_out)
        else $error("Power-good high while an output is under.");
    AST_PG_RISE_90: assert property ($rose(power_ok_out) |->
        $past(ab90 == 2'h3)) else $error("Power-good rose below 90.");
    AST_PG_PERIOD: assert property ($rose(power_ok_out) |->
        $past(q.chk_q) >= RPW'(RP_CYC - 1))
        else $error("Power-good rose before the reset period.");
    AST_PG_OPEN_DRAIN: assert property (
        power_ok_oe_out != power_ok_out)
        else $error("Power-good enable not opposite to level.");
    AST_HICCUP_OFF: assert property ((q.st == dbsfm_pkg::ST_HICCUP) |->
        (channel_enable_out == 2'h0 && !power_ok_out))
        else $error("Channel running during hiccup off time.");
    AST_HICCUP_LEN: assert property (($past(q.st) == dbsfm_pkg::ST_HICCUP
        && q.st == dbsfm_pkg::ST_RUN) |-> $past(q.chk_h) == HCW'(HIC_CYC))
        else $error("Hiccup off time has the wrong length.");
    AST_HS_INHIBIT: assert property ((q.s2[7:6] != 2'h0) |=>
        ((overshoot_guard_out & $past(q.s2[7:6])) == $past(q.s2[7:6])))
        else $error("High-side switch not inhibited on overshoot.");
    AST_HS_RELEASE: assert property (((~overshoot_guard_out &
        $past(overshoot_guard_out)) != 2'h0 && !$past(reset_in)) |->
        $past(switch_tick_in)) else $error("Inhibit released off a tick.");
    AST_SKIP: assert property (!$past(reset_in, 3) |->
        pulse_skip_out == $past(light_load_select_alt_in, 3))
        else $error("Pulse-skip does not follow the select pin.");
    AST_THERM_OFF: assert property (hot |=>
        (q.st == dbsfm_pkg::ST_THERMAL && channel_enable_out == 2'h0))
        else $error("Switching not stopped when hot.");
    AST_THERM_EXIT: assert property (($past(q.st) ==
        dbsfm_pkg::ST_THERMAL && q.st == dbsfm_pkg::ST_RUN) |->
        $past(q.s2[11] && !hot)) else $error("Thermal exit while hot.");

    COV_HICCUP: cover property (q.st == dbsfm_pkg::ST_RUN ##1
        q.st == dbsfm_pkg::ST_HICCUP);
    COV_THERMAL: cover property (q.st == dbsfm_pkg::ST_THERMAL ##1
        q.st == dbsfm_pkg::ST_RUN);
    COV_PG_UP: cover property ($rose(power_ok_out));
endmodule // dbsfm_supervisor

// file: test/dbsfm_host_model.sv
// Host processor model: drives the low-power select and watches the
// power-good pin. Assumes the pin has a pull-up, so released reads high.
`timescale 1ns/10ps
module dbsfm_host_model (
    input wire logic clock_in, // Host clock
    input wire logic standby_in, // Host asks for low-power operation
    input wire logic heavy_load_in, // Load above 100 mA expected
    input wire logic pg_oe_in, // Power-good pull-down enable
    output logic light_load_select_alt_out = 1'h0, // Low-power select
    output logic pin_level_out, // Resolved power-good pin level
    output logic host_reset_n_out // Host held in reset while low
);
    assign pin_level_out = pg_oe_in ? 1'h0 : 1'h1;
    assign host_reset_n_out = pin_level_out;
    always @(posedge clock_in) begin
        light_load_select_alt_out <= standby_in & ~heavy_load_in;
    end
endmodule // dbsfm_host_model

// file: test/test_dbsfm_supervisor.sv
// Self-checking bench of the supervisor with short timer parameters.
// Assumes the host model file is compiled first.
`timescale 1ns/10ps
module test_dbsfm_supervisor;
    localparam int UV = 8;
    localparam int OT = 4;
    localparam int OC = 20;
    localparam int HIC = 30;
    localparam int RP = 16;
    logic clock_in = 1'h0;
    logic reset_in = 1'h1;
    logic [1:0] under_85 = 2'h0, above_90 = 2'h0, overcurrent = 2'h0;
    logic [1:0] fb_over = 2'h0, fb_clear = 2'h0, ch_en, guard;
    logic temp_trip = 1'h0, temp_cool = 1'h0, tick = 1'h0, standby = 1'h0;
    logic heavy = 1'h0, pg, pg_oe, skip, lp, pin;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
    logic rready = 1'h0, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_errors = 0;
    int cmp_count = 0;
    always #5 clock_in = ~clock_in;
    dbsfm_supervisor #(.UV_DEG_CYC(UV), .OT_DEG_CYC(OT), .OC_CYC(OC),
        .HIC_CYC(HIC), .RP_CYC(RP)) u_dbsfm_supervisor (
        .clock_in(clock_in), .reset_in(reset_in), .under_85_in(under_85),
        .above_90_in(above_90), .overcurrent_in(overcurrent),
        .feedback_sense_over_in(fb_over), .feedback_sense_clear_in(fb_clear),
        .temp_trip_in(temp_trip), .temp_cool_in(temp_cool),
        .light_load_select_alt_in(lp), .switch_tick_in(tick),
        .power_ok_in(pin), .power_ok_out(pg), .power_ok_oe_out(pg_oe),
        .channel_enable_out(ch_en), .overshoot_guard_out(guard),
        .pulse_skip_out(skip), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
    dbsfm_host_model u_dbsfm_host_model (.clock_in(clock_in),
        .standby_in(standby), .heavy_load_in(heavy), .pg_oe_in(pg_oe),
        .light_load_select_alt_out(lp), .pin_level_out(pin),
        .host_reset_n_out());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge clock_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic wait_pg(input logic v, input int lim, output int n);
        n = 0;
        while (pg !== v && n < lim) begin
            @(posedge clock_in);
            n++;
        end
    endtask
    task automatic wait_en(input logic [1:0] v, input int lim, output int n);
        n = 0;
        while (ch_en !== v && n < lim) begin
            @(posedge clock_in);
            n++;
        end
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        check(pg_oe, 1'h1);
        axi_rd(8'h00, d, r);
        check(d, 32'h0000_0003);
        axi_rd(8'h10, d, r);
        check(r, 2'h2);
        axi_wr(8'h04, 32'h0000_0000, r);
        check(r, 2'h2);
        axi_wr(8'h00, 32'h0000_0002, r);
        check(r, 2'h0);
        repeat (3) @(posedge clock_in);
        check(ch_en, 2'h2);
        axi_wr(8'h00, 32'h0000_0003, r);
        axi_rd(8'h00, d, r);
        check(d, 32'h0000_0003);
    endtask
    task automatic t_power_good();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        above_90 <= 2'h1;
        wait_pg(1'h1, 2 * (UV + RP), n);
        check(pg, 1'h0);
        @(posedge clock_in);
        above_90 <= 2'h3;
        wait_pg(1'h1, 2 * (UV + RP), n);
        check(n >= UV + RP, 1'h1);
        check(n <= UV + RP + 8, 1'h1);
        check(pin, 1'h1);
        axi_rd(8'h04, d, r);
        check(d, 32'h0001_0c39);
        @(posedge clock_in);
        under_85 <= 2'h2;
        repeat (UV - 3) @(posedge clock_in);
        under_85 <= 2'h0;
        wait_pg(1'h0, 2 * UV + 4, n);
        check(pg, 1'h1);
        @(posedge clock_in);
        under_85 <= 2'h2;
        wait_pg(1'h0, UV + 8, n);
        check(pg, 1'h0);
        check(n >= UV, 1'h1);
        @(posedge clock_in);
        check(pin, 1'h0);
        under_85 <= 2'h0;
    endtask
    task automatic t_overshoot();
        @(posedge clock_in);
        fb_over <= 2'h1;
        repeat (4) @(posedge clock_in);
        check(guard, 2'h1);
        fb_over <= 2'h0;
        fb_clear <= 2'h1;
        repeat (4) @(posedge clock_in);
        check(guard, 2'h1);
        tick <= 1'h1;
        @(posedge clock_in);
        tick <= 1'h0;
        repeat (2) @(posedge clock_in);
        check(guard, 2'h0);
    endtask
    task automatic t_low_power();
        standby <= 1'h1;
        repeat (6) @(posedge clock_in);
        check(skip, 1'h1);
        heavy <= 1'h1;
        repeat (6) @(posedge clock_in);
        check(skip, 1'h0);
    endtask
    task automatic t_short_oc();
        int n;
        overcurrent <= 2'h2;
        repeat (OC / 2) @(posedge clock_in);
        overcurrent <= 2'h0;
        repeat (6) @(posedge clock_in);
        check(ch_en, 2'h1);
        wait_en(2'h3, 30, n);
        check(ch_en, 2'h3);
    endtask
    task automatic t_hiccup();
        int n;
        wait_pg(1'h1, 2 * (UV + RP), n);
        overcurrent <= 2'h1;
        wait_en(2'h0, OC + 10, n);
        check(n >= OC, 1'h1);
        @(posedge clock_in);
        check(pg, 1'h0);
        wait_en(2'h3, HIC + 5, n);
        check(n >= HIC - 2, 1'h1);
        wait_en(2'h0, OC + 10, n);
        check(ch_en, 2'h0);
        overcurrent <= 2'h0;
        wait_en(2'h3, HIC + 20, n);
        // The reset period counts from the restart edge itself.
        wait_pg(1'h1, 2 * (UV + RP), n);
        check(n >= RP - 1, 1'h1);
        repeat (OC + 10) @(posedge clock_in);
        check(ch_en, 2'h3);
    endtask
    task automatic t_thermal();
        int n;
        temp_trip <= 1'h1;
        repeat (OT - 2) @(posedge clock_in);
        temp_trip <= 1'h0;
        repeat (OT + 6) @(posedge clock_in);
        check(ch_en, 2'h3);
        temp_trip <= 1'h1;
        wait_en(2'h0, OT + 8, n);
        check(ch_en, 2'h0);
        @(posedge clock_in);
        check(pg, 1'h0);
        temp_trip <= 1'h0;
        repeat (OT + 8) @(posedge clock_in);
        check(ch_en, 2'h0);
        temp_cool <= 1'h1;
        wait_en(2'h3, OT + 10, n);
        check(ch_en, 2'h3);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock_in);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clock_in);
        reset_in <= 1'h0;
        @(posedge clock_in);
        t_regs();
        t_power_good();
        t_overshoot();
        t_low_power();
        t_short_oc();
        t_hiccup();
        t_thermal();
        report_and_stop();
    end
endmodule // test_dbsfm_supervisor
